//--- dbdc_top.sv
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module dbdc_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Register port.
  input wire logic [dbdc_pkg::REG_A_W-1:0] regAddr,
  input wire logic [dbdc_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [dbdc_pkg::DATA_W-1:0] regRdData,
  // Processor core side of the bridge.
  input wire logic coreReq,
  input wire logic coreWe,
  input wire logic [dbdc_pkg::ADDR_W-1:0] coreAddr,
  input wire logic [dbdc_pkg::DATA_W-1:0] coreWrData,
  input wire logic coreRegHit,
  input wire logic coreCsHit,
  output logic coreAck,
  output logic [dbdc_pkg::DATA_W-1:0] coreRdData,
  // Graphics unit burst port.
  input wire logic gfxReq,
  input wire logic gfxWe,
  input wire logic [dbdc_pkg::ADDR_W-1:0] gfxAddr,
  input wire logic [dbdc_pkg::BURST_W-1:0] gfxLen,
  input wire logic [dbdc_pkg::DATA_W-1:0] gfxWrData,
  output logic gfxWrTake,
  output logic [dbdc_pkg::DATA_W-1:0] gfxRdData,
  output logic gfxRdValid,
  output logic gfxDone,
  // DRAM pins.
  output logic [dbdc_pkg::DRAM_A_W-1:0] dramAddr,
  output logic [dbdc_pkg::NUM_BANKS-1:0] dramRasN,
  output logic dramCasN,
  output logic dramWeN,
  output logic [dbdc_pkg::DATA_W-1:0] dramDqOut,
  output logic dramDqOe,
  input wire logic [dbdc_pkg::DATA_W-1:0] dramDqIn
);
  // Row address of a byte address.
  function automatic logic [dbdc_pkg::DRAM_A_W-1:0] rowOf(input logic [dbdc_pkg::ADDR_W-1:0] a,
                                                          input logic [1:0] size);
    unique case (size)
      dbdc_pkg::SIZE_512K: rowOf = {2'h0, a[18:10]};
      dbdc_pkg::SIZE_2M: rowOf = {1'h0, a[20:11]};
      default: rowOf = a[22:12];
    endcase
  endfunction

  // Column address of a byte address.
  function automatic logic [dbdc_pkg::DRAM_A_W-1:0] colOf(input logic [dbdc_pkg::ADDR_W-1:0] a,
                                                          input logic [1:0] size);
    unique case (size)
      dbdc_pkg::SIZE_512K: colOf = {2'h0, a[9:1]};
      dbdc_pkg::SIZE_2M: colOf = {1'h0, a[10:1]};
      default: colOf = a[11:1];
    endcase
  endfunction

  // Last column-phase cycle of a timing profile.
  function automatic logic [dbdc_pkg::TCNT_W-1:0] colLastOf(input logic [1:0] tim);
    unique case (tim)
      dbdc_pkg::TIM_3CLK: colLastOf = dbdc_pkg::COL_LAST_3CLK;
      dbdc_pkg::TIM_4CLK: colLastOf = dbdc_pkg::COL_LAST_4CLK;
      default: colLastOf = dbdc_pkg::COL_LAST_5CLK;
    endcase
  endfunction

  dbdc_pkg::dbdc_state_e state_reg, state_next;
  dbdc_pkg::dbdc_src_e src_reg;
  logic [dbdc_pkg::TCNT_W-1:0] tcnt_reg, tcnt_next;
  logic [dbdc_pkg::BANK_IDX_W-1:0] bank_reg;
  logic [1:0] size_reg;
  logic [1:0] tim_reg;
  logic [dbdc_pkg::ADDR_W-1:0] curAddr_reg;
  logic we_reg;
  logic [dbdc_pkg::BURST_W-1:0] left_reg;
  logic wbufFull_reg;
  logic [dbdc_pkg::ADDR_W-1:0] wbufAddr_reg;
  logic [dbdc_pkg::DATA_W-1:0] wbufData_reg;
  logic [dbdc_pkg::REF_W-1:0] refCnt_reg;
  logic [dbdc_pkg::REF_W-1:0] refInterval_reg;
  logic refPend_reg;
  logic [dbdc_pkg::BASE_W-1:0] bankBase_reg [dbdc_pkg::NUM_BANKS];
  logic [dbdc_pkg::CFG_W-1:0] bankCfg_reg [dbdc_pkg::NUM_BANKS];
  logic [dbdc_pkg::DATA_W-1:0] regRdData_reg;
  logic [dbdc_pkg::DATA_W-1:0] dqMeta_reg;
  logic [dbdc_pkg::DATA_W-1:0] dqSync_reg;
  logic [dbdc_pkg::DATA_W-1:0] dqOut_reg;
  logic [dbdc_pkg::DATA_W-1:0] coreRdData_reg;
  logic [dbdc_pkg::DATA_W-1:0] gfxRdData_reg;
  logic coreRdAck_reg;
  logic gfxRdValid_reg;
  logic cap1_reg, cap2_reg;
  logic capGfx1_reg, capGfx2_reg;
  logic [dbdc_pkg::DATA_W-1:0] rdMux;

  // One decoder per side.
  dbdc_bank_if gfxIf ();
  dbdc_bank_if sideIf ();
  dbdc_bank_decode uGfxDec (.bus(gfxIf));
  dbdc_bank_decode uSideDec (.bus(sideIf));
  assign gfxIf.lookAddr = gfxAddr;
  assign sideIf.lookAddr = wbufFull_reg ? wbufAddr_reg : coreAddr;
  assign gfxIf.base = bankBase_reg;
  assign gfxIf.cfg = bankCfg_reg;
  assign sideIf.base = bankBase_reg;
  assign sideIf.cfg = bankCfg_reg;

  // A register or chip-select hit leaves DRAM alone.
  wire coreDram = coreReq && !wbufFull_reg && sideIf.hit && !coreRegHit && !coreCsHit; // R2 R15
  wire coreWrAccept = coreDram && coreWe; // R3 R4
  wire idle = (state_reg == dbdc_pkg::ST_IDLE);

  // Idle priority: refresh, graphics, buffered write, core read.
  wire refGo = idle && refPend_reg; // R16
  wire gfxGo = idle && !refPend_reg && gfxReq && gfxIf.hit; // R1
  wire gfxMiss = idle && !refPend_reg && gfxReq && !gfxIf.hit;
  wire wbGo = idle && !refPend_reg && !gfxReq && wbufFull_reg && sideIf.hit; // R4
  wire wbDrop = idle && !refPend_reg && !gfxReq && wbufFull_reg && !sideIf.hit;
  wire coreGo = idle && !refPend_reg && !gfxReq && coreDram && !coreWe; // R1
  wire anyGo = gfxGo || wbGo || coreGo;

  // Column phase timing.
  wire inCol = (state_reg == dbdc_pkg::ST_COL);
  wire colLast = inCol && (tcnt_reg == colLastOf(tim_reg)); // R8
  wire burstEnd = colLast && (left_reg == '0);
  wire capStart = colLast && !we_reg;
  wire pipeBusy = cap1_reg || cap2_reg || coreRdAck_reg || gfxRdValid_reg;

  // Sequencer; refresh never cuts a burst.
  always_comb
  begin
    state_next = state_reg;
    tcnt_next = '0;
    unique case (state_reg)
      dbdc_pkg::ST_IDLE:
      begin
        if (refGo)
          state_next = dbdc_pkg::ST_REF_CAS; // R16
        else if (anyGo)
          state_next = dbdc_pkg::ST_ROW;
      end
      dbdc_pkg::ST_ROW:
        state_next = dbdc_pkg::ST_COL;
      dbdc_pkg::ST_COL:
      begin
        if (burstEnd)
          state_next = dbdc_pkg::ST_PRE;
        else if (!colLast)
          tcnt_next = tcnt_reg + 3'h1; // R5
      end
      dbdc_pkg::ST_PRE:
      begin
        if (!pipeBusy)
          state_next = dbdc_pkg::ST_IDLE;
      end
      dbdc_pkg::ST_REF_CAS:
      begin
        if (tcnt_reg == dbdc_pkg::REF_CAS_LAST)
          state_next = dbdc_pkg::ST_REF_RAS; // R11
        else
          tcnt_next = tcnt_reg + 3'h1;
      end
      dbdc_pkg::ST_REF_RAS:
      begin
        if (tcnt_reg == dbdc_pkg::REF_RAS_LAST)
          state_next = dbdc_pkg::ST_PRE;
        else
          tcnt_next = tcnt_reg + 3'h1;
      end
    endcase
  end

  // Sequencer state.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= dbdc_pkg::ST_IDLE;
      tcnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      tcnt_reg <= tcnt_next;
    end
  end

  // Access context, taken at grant, stepped along a burst.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      src_reg <= dbdc_pkg::SRC_GFX;
      bank_reg <= '0;
      size_reg <= dbdc_pkg::SIZE_512K;
      tim_reg <= dbdc_pkg::TIM_3CLK;
      curAddr_reg <= '0;
      we_reg <= 1'b0;
      left_reg <= '0;
    end
    else if (gfxGo)
    begin
      src_reg <= dbdc_pkg::SRC_GFX;
      bank_reg <= gfxIf.bankIdx;
      size_reg <= gfxIf.sizeCode;
      tim_reg <= gfxIf.timCode;
      curAddr_reg <= gfxAddr;
      we_reg <= gfxWe;
      left_reg <= gfxLen; // R5
    end
    else if (wbGo || coreGo)
    begin
      src_reg <= wbGo ? dbdc_pkg::SRC_WBUF : dbdc_pkg::SRC_CORE;
      bank_reg <= sideIf.bankIdx;
      size_reg <= sideIf.sizeCode;
      tim_reg <= sideIf.timCode;
      curAddr_reg <= wbGo ? wbufAddr_reg : coreAddr;
      we_reg <= wbGo;
      left_reg <= '0;
    end
    else if (colLast && !burstEnd)
    begin
      curAddr_reg <= curAddr_reg + 28'h2;
      left_reg <= left_reg - 4'h1;
    end
  end

  // Posted write buffer; freed at its drain grant.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wbufFull_reg <= 1'b0;
      wbufAddr_reg <= '0;
      wbufData_reg <= '0;
    end
    else if (coreWrAccept)
    begin
      wbufFull_reg <= 1'b1; // R3
      wbufAddr_reg <= coreAddr;
      wbufData_reg <= coreWrData;
    end
    else if (wbGo || wbDrop)
      wbufFull_reg <= 1'b0;
  end

  // Write data load at the drain grant, or for graphics in column cycle 0, before the strobe falls.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dqOut_reg <= '0;
    else if (wbGo)
      dqOut_reg <= wbufData_reg;
    else if (inCol && (tcnt_reg == '0) && (src_reg == dbdc_pkg::SRC_GFX))
      dqOut_reg <= gfxWrData;
  end

  // Refresh timer runs from reset; set wins over a start.
  wire refTick = (refCnt_reg == '0);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      refCnt_reg <= dbdc_pkg::REFRESH_DEFAULT; // R12
      refPend_reg <= 1'b0;
    end
    else
    begin
      refCnt_reg <= refTick ? refInterval_reg : refCnt_reg - 12'h1;
      refPend_reg <= refTick || (refPend_reg && !refGo);
    end
  end

  // Data pins pass two flops; the capture strobe is delayed to match.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dqMeta_reg <= '0;
      dqSync_reg <= '0;
      cap1_reg <= 1'b0;
      cap2_reg <= 1'b0;
      capGfx1_reg <= 1'b0;
      capGfx2_reg <= 1'b0;
    end
    else
    begin
      dqMeta_reg <= dramDqIn;
      dqSync_reg <= dqMeta_reg;
      cap1_reg <= capStart;
      cap2_reg <= cap1_reg;
      capGfx1_reg <= (src_reg == dbdc_pkg::SRC_GFX);
      capGfx2_reg <= capGfx1_reg;
    end
  end

  // Read results to the access owner.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      coreRdData_reg <= '0;
      gfxRdData_reg <= '0;
      coreRdAck_reg <= 1'b0;
      gfxRdValid_reg <= 1'b0;
    end
    else
    begin
      coreRdAck_reg <= cap2_reg && !capGfx2_reg;
      gfxRdValid_reg <= cap2_reg && capGfx2_reg; // R5
      if (cap2_reg && !capGfx2_reg)
        coreRdData_reg <= dqSync_reg;
      if (cap2_reg && capGfx2_reg)
        gfxRdData_reg <= dqSync_reg;
    end
  end

  // Register writes; banks reset disabled.
  genvar b;
  generate
    for (b = 0; b < dbdc_pkg::NUM_BANKS; b++)
    begin : gBankReg
      localparam logic [dbdc_pkg::REG_A_W-1:0] OFS = dbdc_pkg::REG_A_W'(b * dbdc_pkg::BANK_STRIDE);
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          bankBase_reg[b] <= dbdc_pkg::BASE_RESET;
          bankCfg_reg[b] <= dbdc_pkg::CFG_RESET; // R9
        end
        else if (regWr && (regAddr == dbdc_pkg::BANK_BASE_OFS + OFS))
          bankBase_reg[b] <= regWrData[dbdc_pkg::BASE_W-1:0]; // R6
        else if (regWr && (regAddr == dbdc_pkg::BANK_CFG_OFS + OFS))
          bankCfg_reg[b] <= regWrData[dbdc_pkg::CFG_W-1:0]; // R8 R14
      end
    end
  endgenerate

  // New interval applies at the next timer reload.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      refInterval_reg <= dbdc_pkg::REFRESH_DEFAULT;
    else if (regWr && (regAddr == dbdc_pkg::REFRESH_OFS))
      refInterval_reg <= regWrData[dbdc_pkg::REF_W-1:0]; // R12
  end

  // Unmapped offsets read as zero.
  always_comb
  begin
    rdMux = '0;
    for (int i = 0; i < dbdc_pkg::NUM_BANKS; i++)
    begin
      if (regAddr == dbdc_pkg::BANK_BASE_OFS + dbdc_pkg::REG_A_W'(i * dbdc_pkg::BANK_STRIDE))
        rdMux = {7'h0, bankBase_reg[i]};
      if (regAddr == dbdc_pkg::BANK_CFG_OFS + dbdc_pkg::REG_A_W'(i * dbdc_pkg::BANK_STRIDE))
        rdMux = {11'h0, bankCfg_reg[i]};
    end
    if (regAddr == dbdc_pkg::REFRESH_OFS)
      rdMux = {4'h0, refInterval_reg};
    if (regAddr == dbdc_pkg::STATUS_OFS)
    begin
      rdMux[dbdc_pkg::STAT_REFPEND_BIT] = refPend_reg;
      rdMux[dbdc_pkg::STAT_WBUF_BIT] = wbufFull_reg;
      rdMux[dbdc_pkg::STAT_BUSY_BIT] = !idle;
    end
  end

  // Read data stand one cycle only.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      regRdData_reg <= '0;
    else
      regRdData_reg <= regRd ? rdMux : 16'h0;
  end

  // DRAM strobes decode from the sequencer flops.
  wire rowActive = (state_reg == dbdc_pkg::ST_ROW) || inCol;
  wire refRas = (state_reg == dbdc_pkg::ST_REF_RAS);
  genvar r;
  generate
    for (r = 0; r < dbdc_pkg::NUM_BANKS; r++)
    begin : gRas
      assign dramRasN[r] = !((rowActive && (bank_reg == dbdc_pkg::BANK_IDX_W'(r))) || refRas); // R17
    end
  endgenerate
  assign dramCasN = !((inCol && (tcnt_reg != '0)) ||
                      (state_reg == dbdc_pkg::ST_REF_CAS) || refRas); // R11
  assign dramWeN = !(inCol && we_reg); // R10
  assign dramDqOe = inCol && we_reg; // R10
  assign dramDqOut = dqOut_reg;
  assign dramAddr = inCol ? colOf(curAddr_reg, size_reg) : rowOf(curAddr_reg, size_reg); // R7

  // Requester handshakes.
  assign coreAck = coreWrAccept || coreRdAck_reg; // R4
  assign coreRdData = coreRdData_reg;
  assign gfxWrTake = colLast && we_reg && (src_reg == dbdc_pkg::SRC_GFX);
  assign gfxDone = (burstEnd && (src_reg == dbdc_pkg::SRC_GFX)) || gfxMiss;
  assign gfxRdData = gfxRdData_reg;
  assign gfxRdValid = gfxRdValid_reg;
  assign regRdData = regRdData_reg;
endmodule
`default_nettype wire

//--- dbdc_pkg.sv
// Summary of operation
// R1: Arbiter serves core and graphics; graphics always wins when both request.
// R2: Core accesses that miss DRAM never occupy or stall the graphics bus.
// R3: Bridge holds exactly one posted core write in a one-word buffer.
// R4: Posted write acks with zero waits; drains only when graphics is idle.
// R5: Graphics engines reach DRAM by burst reads and burst writes.
// R6: Six banks, each with its own size and base, gaps allowed.
// R7: Address is multiplexed into row and column, up to 8M per bank.
// R8: Each bank selects a 3, 4 or 5 clock fast-page access.
// R9: Reset leaves every bank disabled until software enables it.
// R10: Dedicated 16-bit DRAM data bus with its own write enable.
// R11: Refresh drops column strobe before row strobe.
// R12: Refresh runs from reset at a default rate; interval is programmable.
// R13: Bank decode compares a 28-bit address.
// R14: Bank size is one of 512K, 2M or 8M.
// R15: Register or chip-select hits take priority; DRAM stays idle then.
// R16: Pending refresh goes between accesses, ahead of waiting requesters.
// R17: A disabled bank never drops its row strobe for a normal access.
package dbdc_pkg;
  localparam int NUM_BANKS = 6;
  localparam int ADDR_W = 28;
  localparam int DATA_W = 16;
  localparam int DRAM_A_W = 11;
  localparam int BASE_LSB = 19;
  localparam int BASE_W = 9;
  localparam int BANK_IDX_W = 3;
  localparam int BURST_W = 4;
  localparam int TCNT_W = 3;
  // Size codes; code 3 is illegal and never hits.
  localparam logic [1:0] SIZE_512K = 2'h0;
  localparam logic [1:0] SIZE_2M = 2'h1;
  localparam logic [1:0] SIZE_8M = 2'h2;
  localparam logic [BASE_W-1:0] MASK_512K = 9'h1FF;
  localparam logic [BASE_W-1:0] MASK_2M = 9'h1FC;
  localparam logic [BASE_W-1:0] MASK_8M = 9'h1F0;
  // Timing codes and each one's last column-phase index.
  localparam logic [1:0] TIM_3CLK = 2'h0;
  localparam logic [1:0] TIM_4CLK = 2'h1;
  localparam logic [1:0] TIM_5CLK = 2'h2;
  localparam logic [TCNT_W-1:0] COL_LAST_3CLK = 3'h1;
  localparam logic [TCNT_W-1:0] COL_LAST_4CLK = 3'h2;
  localparam logic [TCNT_W-1:0] COL_LAST_5CLK = 3'h3;
  // Bank configuration word fields.
  localparam int CFG_W = 5;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_SIZE_LSB = 1;
  localparam int CFG_TIM_LSB = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h0;
  localparam logic [BASE_W-1:0] BASE_RESET = 9'h0;
  // Register port offsets.
  localparam int REG_A_W = 8;
  localparam logic [REG_A_W-1:0] BANK_BASE_OFS = 8'h00;
  localparam logic [REG_A_W-1:0] BANK_CFG_OFS = 8'h01;
  localparam int BANK_STRIDE = 2;
  localparam logic [REG_A_W-1:0] REFRESH_OFS = 8'h10;
  localparam logic [REG_A_W-1:0] STATUS_OFS = 8'h11;
  localparam int STAT_REFPEND_BIT = 0;
  localparam int STAT_WBUF_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  // Refresh timing.
  localparam int CLK_PERIOD_NS = 25;
  localparam int REFRESH_NS = 15600;
  localparam int REF_W = 12;
  localparam logic [REF_W-1:0] REFRESH_DEFAULT = REF_W'(REFRESH_NS / CLK_PERIOD_NS);
  localparam logic [TCNT_W-1:0] REF_CAS_LAST = 3'h0;
  localparam logic [TCNT_W-1:0] REF_RAS_LAST = 3'h1;
  typedef enum logic [2:0] {ST_IDLE, ST_ROW, ST_COL, ST_PRE, ST_REF_CAS, ST_REF_RAS} dbdc_state_e;
  typedef enum logic [1:0] {SRC_GFX, SRC_WBUF, SRC_CORE} dbdc_src_e;
endpackage

//--- dbdc_bank_if.sv
`timescale 1ns/10ps
`default_nettype none
// Bank setup in, decode result out, for one address.
interface dbdc_bank_if;
  logic [dbdc_pkg::ADDR_W-1:0] lookAddr;
  logic [dbdc_pkg::BASE_W-1:0] base [dbdc_pkg::NUM_BANKS];
  logic [dbdc_pkg::CFG_W-1:0] cfg [dbdc_pkg::NUM_BANKS];
  logic hit;
  logic [dbdc_pkg::BANK_IDX_W-1:0] bankIdx;
  logic [1:0] sizeCode;
  logic [1:0] timCode;
  modport decoder (input lookAddr, input base, input cfg, output hit, output bankIdx,
                   output sizeCode, output timCode);
  modport ctrl (output lookAddr, output base, output cfg, input hit, input bankIdx,
                input sizeCode, input timCode);
endinterface
`default_nettype wire

//--- dbdc_bank_decode.sv
`timescale 1ns/10ps
`default_nettype none
module dbdc_bank_decode (
  // Lookup and result.
  dbdc_bank_if.decoder bus
);
  // Base bits compared for a size.
  function automatic logic [dbdc_pkg::BASE_W-1:0] sizeMask(input logic [1:0] size);
    unique case (size)
      dbdc_pkg::SIZE_512K: sizeMask = dbdc_pkg::MASK_512K;
      dbdc_pkg::SIZE_2M: sizeMask = dbdc_pkg::MASK_2M;
      default: sizeMask = dbdc_pkg::MASK_8M;
    endcase
  endfunction

  logic [dbdc_pkg::NUM_BANKS-1:0] bankHit;
  wire [dbdc_pkg::BASE_W-1:0] addrTop = bus.lookAddr[dbdc_pkg::ADDR_W-1:dbdc_pkg::BASE_LSB]; // R13

  // A bank hits only when enabled with a legal size.
  genvar g;
  generate
    for (g = 0; g < dbdc_pkg::NUM_BANKS; g++)
    begin : gBank
      wire [1:0] sz = bus.cfg[g][dbdc_pkg::CFG_SIZE_LSB +: 2];
      assign bankHit[g] = bus.cfg[g][dbdc_pkg::CFG_EN_BIT] && (sz != 2'h3) &&
        (((addrTop ^ bus.base[g]) & sizeMask(sz)) == '0); // R6 R14 R17
    end
  endgenerate

  // Lowest index wins on overlap.
  always_comb
  begin
    bus.hit = 1'b0;
    bus.bankIdx = '0;
    for (int i = dbdc_pkg::NUM_BANKS - 1; i >= 0; i--)
    begin
      if (bankHit[i])
      begin
        bus.hit = 1'b1;
        bus.bankIdx = dbdc_pkg::BANK_IDX_W'(i);
      end
    end
  end

  assign bus.sizeCode = bus.cfg[bus.bankIdx][dbdc_pkg::CFG_SIZE_LSB +: 2];
  assign bus.timCode = bus.cfg[bus.bankIdx][dbdc_pkg::CFG_TIM_LSB +: 2];
endmodule
`default_nettype wire

//--- dbdc_dram_model.sv
`timescale 1ns/10ps
`default_nettype none
// Fast-page DRAM parts; one column store for all banks.
module dbdc_dram_model (
  // Clock.
  input wire logic clk,
  // DRAM pins.
  input wire logic [dbdc_pkg::DRAM_A_W-1:0] dramAddr,
  input wire logic [dbdc_pkg::NUM_BANKS-1:0] dramRasN,
  input wire logic dramCasN,
  input wire logic dramWeN,
  input wire logic [dbdc_pkg::DATA_W-1:0] dramDqOut,
  input wire logic dramDqOe,
  output logic [dbdc_pkg::DATA_W-1:0] dramDqIn
);
  logic [dbdc_pkg::DATA_W-1:0] mem [256];
  logic [dbdc_pkg::DATA_W-1:0] lastQ;
  // Column cycle: CAS low under one open row.
  wire colCyc = !dramCasN && $onehot(~dramRasN);
  // Undriven pins show the inverse of the last value, so stale data never matches.
  assign dramDqIn = (colCyc && dramWeN) ? mem[dramAddr[7:0]] : ~lastQ;
  initial lastQ = 16'h0;
  // Writes land at the end of a write column cycle.
  always @(posedge clk)
  begin
    if (colCyc && !dramWeN && dramDqOe)
      mem[dramAddr[7:0]] <= dramDqOut;
    lastQ <= dramDqIn;
  end
endmodule
`default_nettype wire

//--- dbdc_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Watches DRAM pins and requester answers.
module dbdc_top_asserts (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Requesters.
  input wire logic coreReq,
  input wire logic coreRegHit,
  input wire logic coreCsHit,
  input wire logic coreAck,
  input wire logic gfxDone,
  input wire logic gfxRdValid,
  // DRAM pins.
  input wire logic [dbdc_pkg::NUM_BANKS-1:0] dramRasN,
  input wire logic dramCasN,
  input wire logic dramWeN,
  input wire logic dramDqOe
);
  logic [9:0] cycReg;
  logic seenReg;
  // Strobe patterns: all rows open only in refresh.
  wire allRas = (dramRasN == 6'h00);
  wire noRas = (dramRasN == 6'h3F);
  wire colLow = !dramCasN && !noRas && !allRas;
  // Saturating cycle count, to place the first refresh in time.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cycReg <= 10'h0;
      seenReg <= 1'h0;
    end
    else
    begin
      cycReg <= (cycReg == 10'h3FF) ? cycReg : cycReg + 10'h1;
      seenReg <= seenReg | allRas;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Refresh: column strobe alone, then all rows with it.
  sequence refCas;
    !dramCasN && noRas;
  endsequence
  sequence refRas;
    allRas && !dramCasN;
  endsequence
  a_cas_before_ras: assert property (refCas |=> refRas)
    else $error("rows did not follow column strobe");
  a_ras_needs_cas: assert property (allRas |-> !dramCasN && !$past(dramCasN))
    else $error("rows opened before column strobe");
  a_single_bank: assert property (!allRas |-> $onehot0(~dramRasN))
    else $error("two banks opened for one access");
  a_ref_not_early: assert property (allRas |-> cycReg >= 10'h26C)
    else $error("refresh before default interval");
  a_ref_from_reset: assert property (cycReg == 10'h2BC |-> seenReg)
    else $error("no refresh after reset");
  a_write_oe_we: assert property (dramDqOe |-> !dramWeN && !noRas)
    else $error("data driven outside a write");
  a_other_hit_idle: assert property (coreReq && (coreRegHit || coreCsHit) |-> !coreAck)
    else $error("DRAM answered a foreign hit");
  a_done_on_cas: assert property (gfxDone && !noRas |-> !dramCasN)
    else $error("burst done outside a column strobe");
  a_read_valid_delay: assert property (gfxRdValid |-> $past(colLow, 3))
    else $error("read word mistimed");
endmodule
bind dbdc_top dbdc_top_asserts u_chk (.clk, .arst_n, .coreReq, .coreRegHit, .coreCsHit,
  .coreAck, .gfxDone, .gfxRdValid, .dramRasN, .dramCasN, .dramWeN, .dramDqOe);
`default_nettype wire

//--- dbdc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dbdc_top_tb;
  logic clk, arst_n, regWr, regRd, coreReq, coreWe, coreRegHit, coreCsHit, gfxReq, gfxWe;
  logic coreAck, gfxWrTake, gfxRdValid, gfxDone, dramCasN, dramWeN, dramDqOe, gDone;
  logic [7:0] regAddr;
  logic [15:0] regWrData, regRdData, coreWrData, coreRdData, gfxWrData, gfxRdData;
  logic [15:0] dramDqOut, dramDqIn, q;
  logic [27:0] coreAddr, gfxAddr;
  logic [3:0] gfxLen;
  logic [10:0] dramAddr;
  logic [5:0] dramRasN, ras;
  logic [15:0] rdq [$];
  int fails, checked, cyc, n, m, tc, tg;
  // Controller and DRAM.
  dbdc_top dut (.clk, .arst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .coreReq,
    .coreWe, .coreAddr, .coreWrData, .coreRegHit, .coreCsHit, .coreAck, .coreRdData, .gfxReq,
    .gfxWe, .gfxAddr, .gfxLen, .gfxWrData, .gfxWrTake, .gfxRdData, .gfxRdValid, .gfxDone,
    .dramAddr, .dramRasN, .dramCasN, .dramWeN, .dramDqOut, .dramDqOe, .dramDqIn);
  dbdc_dram_model mdl (.clk, .dramAddr, .dramRasN, .dramCasN, .dramWeN, .dramDqOut,
    .dramDqOe, .dramDqIn);
  // Clock.
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // Read words queue here; the ceiling cuts a hang.
  always @(posedge clk)
  begin
    cyc++;
    if (gfxRdValid === 1'h1)
      rdq.push_back(gfxRdData);
    if (cyc == 6000)
    begin
      fails++;
      results();
    end
  end
  task results();
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    @(negedge clk);
    d = regRdData;
  endtask
  // Cycles to the next refresh.
  task refWait(output int k);
    k = 0;
    while (dramRasN === 6'h00)
      @(negedge clk);
    while (dramRasN !== 6'h00 && k < 5000)
    begin
      @(negedge clk);
      k++;
    end
  endtask
  // One burst; request stands until done, word steps on each take.
  task gfx(input logic we, input logic [27:0] a, input logic [3:0] len, input logic [15:0] d,
           output int k, output logic [5:0] rs);
    logic dn, tk;
    @(posedge clk);
    gfxWe <= we;
    gfxAddr <= a;
    gfxLen <= len;
    gfxWrData <= d;
    gfxReq <= 1'h1;
    k = 0;
    rs = 6'h3F;
    dn = 1'h0;
    while (!dn && k < 200)
    begin
      @(negedge clk);
      rs = rs & dramRasN;
      dn = (gfxDone === 1'h1);
      tk = (gfxWrTake === 1'h1);
      @(posedge clk);
      k++;
      if (tk)
        gfxWrData <= gfxWrData + 16'h1;
    end
    gfxReq <= 1'h0;
  endtask
  // One core access, held until answered or timed out.
  task coreX(input logic we, input logic [27:0] a, input logic [15:0] d, input logic [1:0] h,
             output logic [15:0] rq, output int k);
    @(posedge clk);
    coreReq <= 1'h1;
    coreWe <= we;
    coreAddr <= a;
    coreWrData <= d;
    {coreRegHit, coreCsHit} <= h;
    k = 0;
    @(negedge clk);
    while (coreAck !== 1'h1 && k < 60)
    begin
      @(negedge clk);
      k++;
    end
    rq = coreRdData;
    @(posedge clk);
    coreReq <= 1'h0;
  endtask
  // Single-word read noting row strobes; waits out the pipeline.
  task probe(input logic [27:0] a, input logic [5:0] exp);
    gfx(1'h0, a, 4'h0, 16'h0, n, ras);
    chk(ras, exp);
    repeat (6) @(posedge clk);
    rdq.delete();
  endtask
  task tRefresh();
    refWait(n);
    chk(n >= 626 && n <= 630, 1'h1);
    wr(8'h10, 16'h64);
    refWait(n);
    refWait(n);
    refWait(n);
    chk(n, 99);
    wr(8'h10, 16'hFFF);
    refWait(n);
  endtask
  task tReset();
    for (int i = 0; i < 6; i++)
    begin
      rd(8'(2 * i + 1), q);
      chk(q, 16'h0);
    end
    wr(8'h01, 16'h2);
    probe(28'h10, 6'h3F);
  endtask
  task tDecode();
    wr(8'h01, 16'h1);
    wr(8'h02, 16'h4);
    wr(8'h03, 16'h3);
    wr(8'h06, 16'h1F0);
    wr(8'h07, 16'h5);
    probe(28'h10, 6'h3E);
    probe(28'h80000, 6'h3F);
    probe(28'h3FFFF0, 6'h3D);
    probe(28'h400000, 6'h3F);
    probe(28'hF800010, 6'h37);
    probe(28'h7800010, 6'h3F);
  endtask
  task tTiming();
    for (int t = 0; t < 3; t++)
    begin
      wr(8'h01, 16'(t * 8 + 1));
      probe(28'h10, 6'h3E);
      chk(n, t + 4);
    end
    wr(8'h01, 16'h1);
  endtask
  task tBurst();
    gfx(1'h1, 28'h100, 4'h3, 16'hA5A0, n, ras);
    gfx(1'h0, 28'h100, 4'h3, 16'h0, n, ras);
    repeat (8) @(posedge clk);
    chk(rdq.size(), 4);
    for (int k = 0; k < 4; k++)
      chk(rdq[k], 16'hA5A0 + 16'(k));
  endtask
  task tCore();
    gDone = 1'h0;
    fork
      begin
        gfx(1'h1, 28'h200, 4'hF, 16'h1000, n, ras);
        gDone = 1'h1;
      end
      begin
        repeat (3) @(posedge clk);
        coreX(1'h1, 28'h300, 16'hBEEF, 2'h0, q, m);
        chk(m, 0);
        coreX(1'h1, 28'h302, 16'hCAFE, 2'h0, q, m);
        chk(gDone, 1'h1);
      end
    join
    coreX(1'h0, 28'h300, 16'h0, 2'h0, q, m);
    chk(q, 16'hBEEF);
    coreX(1'h0, 28'h302, 16'h0, 2'h0, q, m);
    chk(q, 16'hCAFE);
    chk(m, 6);
  endtask
  task tArb();
    fork
      coreX(1'h0, 28'h300, 16'h0, 2'h2, q, m);
      gfx(1'h0, 28'h10, 4'h0, 16'h0, n, ras);
    join
    chk(m, 60);
    chk(n, 4);
    repeat (6) @(posedge clk);
    coreX(1'h0, 28'h300, 16'h0, 2'h1, q, m);
    chk(m, 60);
    fork
      begin
        coreX(1'h0, 28'h300, 16'h0, 2'h0, q, m);
        tc = cyc;
      end
      begin
        gfx(1'h0, 28'h10, 4'h0, 16'h0, n, ras);
        tg = cyc;
      end
    join
    chk(tg < tc, 1'h1);
    chk(q, 16'hBEEF);
  endtask
  // Reset eight cycles, then the scenarios.
  initial
  begin
    {arst_n, regWr, regRd, coreReq, coreWe, coreRegHit, coreCsHit, gfxReq, gfxWe} = 9'h0;
    {regAddr, regWrData, coreAddr, coreWrData, gfxAddr, gfxLen, gfxWrData} = 116'h0;
    repeat (8) @(posedge clk);
    chk(dramRasN, 6'h3F);
    arst_n <= 1'h1;
    tRefresh();
    tReset();
    tDecode();
    tTiming();
    tBurst();
    tCore();
    tArb();
    results();
  end
endmodule
`default_nettype wire
